// *** src/hub_cfg_pkg.sv ***
package hub_cfg_pkg;
  localparam logic [7:0] OFF_PRODUCT_ID_LOW = 8'h03;
  localparam logic [7:0] OFF_PRODUCT_ID_HIGH = 8'h04;
  localparam logic [7:0] OFF_DEVICE_CONFIGURATION = 8'h05;
  localparam logic [7:0] OFF_CHARGING_SUPPORT = 8'h06;
  localparam logic [7:0] OFF_LANG_FIRST = 8'h20;
  localparam logic [7:0] OFF_LANG_LAST = 8'h21;
  localparam logic [7:0] OFF_SERIAL_LENGTH = 8'h22;
  localparam logic [7:0] OFF_MFG_LENGTH = 8'h23;
  localparam logic [7:0] OFF_PROD_LENGTH = 8'h24;
  localparam logic [7:0] OFF_SERIAL_FIRST = 8'h30;
  localparam logic [7:0] OFF_SERIAL_LAST = 8'h4F;
  localparam logic [7:0] OFF_STRING_FIRST = 8'h50;
  localparam logic [7:0] OFF_STRING_LAST = 8'hCF;
  localparam int BIT_STRING_WE = 7;
  localparam int BIT_SERIAL_WE = 6;
  localparam int BIT_LP_DISABLE = 5;
  localparam int BIT_RSVD_ONE = 4;
  localparam int BIT_GANGED = 3;
  localparam int BIT_PWR_REPORT_DIS = 2;
  localparam int BIT_TIMEOUT_OVR = 1;
  localparam int BIT_RSVD_ZERO = 0;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hEE;
  localparam logic [7:0] CHG_WRITE_MASK = 8'h0F;
  localparam logic [7:0] USB2_PID_XOR = 8'h02;
  localparam logic [7:0] TIMEOUT_MAX = 8'hFF;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'd4;

  typedef enum logic [1:0] {
    SRC_EEPROM = 2'b00,
    SRC_SMBUS = 2'b01
  } cfg_source_type;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } cfg_write_type;

  typedef struct packed {
    logic string_write_enable;
    logic serial_write_enable;
    logic low_power_link_disable;
    logic ganged;
    logic power_report_disable;
    logic link_timeout_override;
  } cfg_bits_type;
endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; output changes when stages two and three agree.
module pin_sync
  import hub_cfg_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  wire [WIDTH-1:0] agree = ~(s2_ff ^ s3_ff);
  wire [WIDTH-1:0] nxt_level = (agree & s3_ff) | (~agree & level_ff);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;
endmodule

// *** src/hub_device_config_regs.sv ***
`timescale 1ns/1ps
module hub_device_config_regs
  import hub_cfg_pkg::*;
#(
  parameter logic [7:0] PID_LOW_DEFAULT = 8'h5A,
  parameter logic [7:0] PID_HIGH_DEFAULT = 8'hA5,
  parameter int PORTS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire cfg_write_type cfg_write,
  input wire cfg_source_type cfg_source,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic [7:0] otp_product_id_low,
  input wire logic [7:0] otp_product_id_high,
  input wire logic power_share_strap_pin,
  input wire logic power_report_strap_pin,
  input wire logic [PORTS-1:0] port_power_control_pins,
  input wire logic force_accept_event,
  input wire logic upstream_disconnect,
  input wire logic [7:0] host_timeout,
  input wire logic [PORTS-1:0] port_power_request,
  output logic [7:0] ss_product_id_low,
  output logic [7:0] usb2_product_id_low,
  output logic [7:0] product_id_high,
  output logic low_power_link_allowed,
  output logic [7:0] link_timeout,
  output logic [PORTS-1:0] port_power_enable,
  output logic power_report_enable,
  output logic [PORTS-1:0] charging_port_enable,
  output cfg_bits_type cfg_bits,
  output logic string_reg_write,
  output logic serial_reg_write
);
  logic [7:0] pid_low_ff;
  logic [7:0] pid_high_ff;
  logic [7:0] cfg_ff;
  logic [PORTS-1:0] chg_ff;
  logic strap_loaded_ff;
  logic force_accept_ff;
  logic [7:0] ss_pid_low_ff;
  logic [7:0] usb2_pid_low_ff;
  logic [7:0] pid_high_out_ff;
  logic [7:0] link_timeout_ff;
  logic [PORTS-1:0] port_power_ff;
  logic gang_sync;
  logic report_sync;
  logic [PORTS-1:0] pwrctl_sync;

  logic [2:0] strap_wait_ff;
  logic [2:0] nxt_strap_wait;
  logic nxt_strap_loaded;
  logic [7:0] nxt_pid_low;
  logic [7:0] nxt_pid_high;
  logic [7:0] nxt_cfg;
  logic [PORTS-1:0] nxt_chg;
  logic nxt_force_accept;
  logic [7:0] nxt_usb2_pid_low;
  logic [7:0] nxt_timeout;
  logic [PORTS-1:0] nxt_port_power;

  pin_sync #(.WIDTH(1)) u_sync_gang (
    .clk(clk),
    .reset_n(reset_n),
    .pin(power_share_strap_pin),
    .level(gang_sync)
  );

  pin_sync #(.WIDTH(1)) u_sync_report (
    .clk(clk),
    .reset_n(reset_n),
    .pin(power_report_strap_pin),
    .level(report_sync)
  );

  pin_sync #(.WIDTH(PORTS)) u_sync_pwrctl (
    .clk(clk),
    .reset_n(reset_n),
    .pin(port_power_control_pins),
    .level(pwrctl_sync)
  );

  // Synchroniser output settles four edges after release; straps are taken one edge later
  wire strap_take = !strap_loaded_ff && (strap_wait_ff == STRAP_SETTLE_CYCLES);
  assign nxt_strap_wait = (strap_wait_ff != STRAP_SETTLE_CYCLES) ? strap_wait_ff + 3'd1 :
                          strap_wait_ff;
  assign nxt_strap_loaded = strap_loaded_ff || strap_take;

  wire wr = cfg_write.wr;
  wire [7:0] wa = cfg_write.addr;
  wire [7:0] wd = cfg_write.data;
  wire wr_pid_low = wr && (wa == OFF_PRODUCT_ID_LOW);
  wire wr_pid_high = wr && (wa == OFF_PRODUCT_ID_HIGH);
  wire wr_cfg = wr && (wa == OFF_DEVICE_CONFIGURATION);
  wire wr_chg = wr && (wa == OFF_CHARGING_SUPPORT);

  // String and serial storage lives outside; locked writes get no strobe
  wire in_lang = (wa >= OFF_LANG_FIRST) && (wa <= OFF_LANG_LAST);
  wire in_text = (wa >= OFF_STRING_FIRST) && (wa <= OFF_STRING_LAST);
  wire in_text_length = (wa == OFF_MFG_LENGTH) || (wa == OFF_PROD_LENGTH);
  wire in_serial_text = (wa >= OFF_SERIAL_FIRST) && (wa <= OFF_SERIAL_LAST);
  wire in_serial_length = wa == OFF_SERIAL_LENGTH;
  wire in_string = in_lang || in_text || in_text_length;
  wire in_serial = in_serial_text || in_serial_length;
  wire string_unlocked = cfg_ff[BIT_STRING_WE];
  wire serial_unlocked = cfg_ff[BIT_SERIAL_WE];
  assign string_reg_write = wr && in_string && string_unlocked;
  assign serial_reg_write = wr && in_serial && serial_unlocked;

  // Reserved bits are forced whatever the source writes
  wire [7:0] cfg_written = (wd & CFG_WRITE_MASK) | CFG_RESET;
  wire [7:0] cfg_strapped = {cfg_ff[7:4], gang_sync, report_sync,
                             cfg_ff[1:0]};
  // A write in the strap cycle wins over the strap load
  assign nxt_cfg = wr_cfg ? cfg_written : (strap_take ? cfg_strapped : cfg_ff);
  assign nxt_chg = wr_chg ? wd[PORTS-1:0] :
                   (strap_take ? pwrctl_sync : chg_ff);
  assign nxt_pid_low = wr_pid_low ? wd : pid_low_ff;
  assign nxt_pid_high = wr_pid_high ? wd : pid_high_ff;

  // Source priority per byte: written, then one-time-programmable, then default
  wire pid_low_written = pid_low_ff != 8'h00;
  wire pid_low_otp = otp_product_id_low != 8'h00;
  wire pid_high_written = pid_high_ff != 8'h00;
  wire pid_high_otp = otp_product_id_high != 8'h00;
  wire [7:0] pid_low_sel = pid_low_written ? pid_low_ff :
                           pid_low_otp ? otp_product_id_low : PID_LOW_DEFAULT;
  wire [7:0] pid_high_sel = pid_high_written ? pid_high_ff :
                            pid_high_otp ? otp_product_id_high : PID_HIGH_DEFAULT;
  assign nxt_usb2_pid_low = pid_low_sel ^ USB2_PID_XOR;

  // Force-accept latch only arms while low-power states are disabled
  wire lp_disable = cfg_ff[BIT_LP_DISABLE];
  wire force_seen = force_accept_event && lp_disable;
  assign nxt_force_accept = !upstream_disconnect && (force_accept_ff || force_seen);
  wire lp_allowed = !lp_disable || force_accept_ff;
  wire timeout_override = cfg_ff[BIT_TIMEOUT_OVR];
  wire host_timeout_set = host_timeout != 8'h00;
  wire timeout_forced = timeout_override && host_timeout_set;
  assign nxt_timeout = timeout_forced ? TIMEOUT_MAX : host_timeout;
  wire report_disable = cfg_ff[BIT_PWR_REPORT_DIS];
  wire report_en = !report_disable;
  wire ganged = cfg_ff[BIT_GANGED];
  wire [PORTS-1:0] gang_request = {PORTS{port_power_request[0]}};
  // Ports stay powered while status reporting is off
  assign nxt_port_power = !report_en ? {PORTS{1'b1}} :
                          ganged ? gang_request : port_power_request;

  // Register read port is combinational
  wire rd_pid_low = rd_addr == OFF_PRODUCT_ID_LOW;
  wire rd_pid_high = rd_addr == OFF_PRODUCT_ID_HIGH;
  wire rd_cfg = rd_addr == OFF_DEVICE_CONFIGURATION;
  wire rd_chg = rd_addr == OFF_CHARGING_SUPPORT;
  wire [7:0] chg_read = {{(8-PORTS){1'b0}}, chg_ff};
  assign rd_data = rd_pid_low ? pid_low_sel :
                   rd_pid_high ? pid_high_sel :
                   rd_cfg ? cfg_ff :
                   rd_chg ? chg_read : 8'h00;

  // Settling counter for the strap pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait_ff <= 3'd0;
    end else begin
      strap_wait_ff <= nxt_strap_wait;
    end
  end

  // Straps load once per reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_loaded_ff <= 1'b0;
    end else begin
      strap_loaded_ff <= nxt_strap_loaded;
    end
  end

  // Zero means not written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pid_low_ff <= 8'h00;
    end else begin
      pid_low_ff <= nxt_pid_low;
    end
  end

  // Zero means not written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pid_high_ff <= 8'h00;
    end else begin
      pid_high_ff <= nxt_pid_high;
    end
  end

  // Configuration byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Charging enables per port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chg_ff <= '0;
    end else begin
      chg_ff <= nxt_chg;
    end
  end

  // Cleared only by reset or an upstream disconnect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      force_accept_ff <= 1'b0;
    end else begin
      force_accept_ff <= nxt_force_accept;
    end
  end

  // Product ID, timeout and port power outputs trail their sources by one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ss_pid_low_ff <= 8'h00;
    end else begin
      ss_pid_low_ff <= pid_low_sel;
    end
  end

  // Low byte as the USB 2.0 descriptor shows it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      usb2_pid_low_ff <= 8'h00;
    end else begin
      usb2_pid_low_ff <= nxt_usb2_pid_low;
    end
  end

  // High byte after source priority
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pid_high_out_ff <= 8'h00;
    end else begin
      pid_high_out_ff <= pid_high_sel;
    end
  end

  // Downstream timeout after override
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_timeout_ff <= 8'h00;
    end else begin
      link_timeout_ff <= nxt_timeout;
    end
  end

  // Port power switch controls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_power_ff <= '0;
    end else begin
      port_power_ff <= nxt_port_power;
    end
  end

  // Output ports
  assign ss_product_id_low = ss_pid_low_ff;
  assign usb2_product_id_low = usb2_pid_low_ff;
  assign product_id_high = pid_high_out_ff;
  assign low_power_link_allowed = lp_allowed;
  assign link_timeout = link_timeout_ff;
  assign port_power_enable = port_power_ff;
  assign power_report_enable = report_en;
  assign charging_port_enable = chg_ff;
  // Configuration bits as the rest of the hub sees them
  assign cfg_bits = '{
    string_write_enable: string_unlocked,
    serial_write_enable: serial_unlocked,
    low_power_link_disable: lp_disable,
    ganged: ganged,
    power_report_disable: report_disable,
    link_timeout_override: timeout_override
  };
endmodule

// *** test/hub_device_config_regs_props.sv ***
`timescale 1ns/1ps
module hub_cfg_regs_props
  import hub_cfg_pkg::*;
#(
  parameter int PORTS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire cfg_write_type cfg_write,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic force_accept_event,
  input wire logic upstream_disconnect,
  input wire logic [7:0] host_timeout,
  input wire logic [PORTS-1:0] port_power_request,
  input wire logic [7:0] ss_product_id_low,
  input wire logic [7:0] usb2_product_id_low,
  input wire logic low_power_link_allowed,
  input wire logic [7:0] link_timeout,
  input wire logic [PORTS-1:0] port_power_enable,
  input wire logic power_report_enable,
  input wire cfg_bits_type cfg_bits,
  input wire logic string_reg_write,
  input wire logic serial_reg_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [7:0] wa = cfg_write.addr;
  wire ser_hit = cfg_write.wr && (wa inside {OFF_SERIAL_LENGTH, [OFF_SERIAL_FIRST:OFF_SERIAL_LAST]});
  wire str_hit = cfg_write.wr && (wa inside {[OFF_LANG_FIRST:OFF_LANG_LAST], OFF_MFG_LENGTH,
    OFF_PROD_LENGTH, [OFF_STRING_FIRST:OFF_STRING_LAST]});
  sequence s_force;
    cfg_bits.low_power_link_disable && force_accept_event && !upstream_disconnect;
  endsequence
  chk_usb2_pid: assert property ($past(reset_n) |->
    usb2_product_id_low == (ss_product_id_low ^ USB2_PID_XOR)) else $error("usb2 pid");
  chk_cfg_fixed: assert property (rd_addr == OFF_DEVICE_CONFIGURATION |->
    rd_data[BIT_RSVD_ONE] && !rd_data[BIT_RSVD_ZERO]) else $error("cfg fixed bits");
  chk_chg_upper: assert property (rd_addr == OFF_CHARGING_SUPPORT |->
    rd_data[7:4] == 4'h0) else $error("chg upper bits");
  chk_string_gate: assert property (str_hit |->
    string_reg_write == cfg_bits.string_write_enable) else $error("string gate");
  chk_serial_gate: assert property (ser_hit |->
    serial_reg_write == cfg_bits.serial_write_enable) else $error("serial gate");
  chk_timeout_ovr: assert property ($past(reset_n) |-> link_timeout ==
    ($past(cfg_bits.link_timeout_override) ? (($past(host_timeout) != 8'h00) ? TIMEOUT_MAX :
    8'h00) : $past(host_timeout))) else $error("timeout override");
  chk_lp_allowed: assert property (!cfg_bits.low_power_link_disable |->
    low_power_link_allowed) else $error("lp allowed");
  chk_force_keep: assert property (s_force |=> low_power_link_allowed)
    else $error("force keep");
  chk_disc_clear: assert property (cfg_bits.low_power_link_disable &&
    upstream_disconnect && !force_accept_event && !cfg_write.wr |=> !low_power_link_allowed)
    else $error("disc clear");
  chk_report_pin: assert property (power_report_enable ==
    !cfg_bits.power_report_disable) else $error("report enable");
  chk_gang_power: assert property (power_report_enable |=> port_power_enable ==
    ($past(cfg_bits.ganged) ? {PORTS{$past(port_power_request[0])}} : $past(port_power_request)))
    else $error("gang power");
endmodule
bind hub_device_config_regs hub_cfg_regs_props #(.PORTS(PORTS)) i_hub_cfg_regs_props (.*);

// *** test/hub_cfg_source_model.sv ***
`timescale 1ns/1ps
module hub_cfg_source_model
  import hub_cfg_pkg::*;
(
  input wire logic clk,
  output cfg_write_type cfg_write,
  output cfg_source_type cfg_source
);
  initial cfg_write = '0;
  initial cfg_source = SRC_EEPROM;
  // Released bus shows inverted address and data so stale values never match
  task automatic send(input logic [7:0] a, input logic [7:0] d, input cfg_source_type s);
    @(negedge clk);
    cfg_write = '{wr: 1'b1, addr: a, data: d};
    cfg_source = s;
    @(negedge clk);
    cfg_write = '{wr: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule

// *** test/hub_device_config_regs_test.sv ***
`timescale 1ns/1ps
`define CMP(g, e) cmp(8'(g), 8'(e))
module hub_device_config_regs_test;
  import hub_cfg_pkg::*;
  localparam logic [7:0] DEF_LO = 8'h5A;
  localparam logic [7:0] DEF_HI = 8'hA5;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  cfg_write_type cfg_write;
  cfg_source_type cfg_source;
  cfg_bits_type cfg_bits;
  logic [7:0] rd_addr = 8'h00, rd_data, otp_product_id_low = 8'h00, otp_product_id_high;
  logic [7:0] host_timeout = 8'h00, ss_product_id_low, usb2_product_id_low, product_id_high;
  logic [7:0] link_timeout, v;
  logic power_share_strap_pin, power_report_strap_pin, low_power_link_allowed;
  logic force_accept_event = 1'b0, upstream_disconnect = 1'b0, power_report_enable;
  logic string_reg_write, serial_reg_write, rd_go = 1'b0;
  logic [3:0] port_power_control_pins, port_power_request = 4'h0, port_power_enable;
  logic [3:0] charging_port_enable;
  logic [16:0] seed = 17'h1_012f;
  logic [7:0] exp_q[$];
  logic [7:0] gate_q[$];
  int err_total = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  hub_device_config_regs #(.PID_LOW_DEFAULT(DEF_LO), .PID_HIGH_DEFAULT(DEF_HI))
    i_hub_device_config_regs (.*);
  hub_cfg_source_model i_hub_cfg_source_model (.*);
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic rnd();
    seed = lfsr(seed);
    v = seed[7:0] | 8'h01;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_hub_cfg_source_model.send(a, d, cfg_source_type'({1'b0, seed[0]}));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd_addr = a;
    exp_q.push_back(e);
    rd_go = 1'b1;
    @(negedge clk);
    rd_go = 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  task automatic gw(input logic [7:0] a, input logic [1:0] e);
    gate_q.push_back({6'h00, e});
    wr(a, v);
  endtask
  always @(posedge clk) begin
    if (rd_go && exp_q.size() > 0) begin
      `CMP(rd_data, exp_q.pop_front());
    end
    if (cfg_write.wr && gate_q.size() > 0) begin
      `CMP({string_reg_write, serial_reg_write}, gate_q.pop_front());
    end
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    tally_and_finish();
  end
  initial begin
    rnd();
    otp_product_id_high = v;
    {power_share_strap_pin, power_report_strap_pin, port_power_control_pins} = seed[5:0];
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    v = {4'h1, power_share_strap_pin, power_report_strap_pin, 2'b00};
    rd(OFF_DEVICE_CONFIGURATION, v);
    rd(OFF_CHARGING_SUPPORT, {4'h0, port_power_control_pins});
    rd(OFF_PRODUCT_ID_LOW, DEF_LO);
    rd(OFF_PRODUCT_ID_HIGH, otp_product_id_high);
    `CMP(charging_port_enable, port_power_control_pins);
    `CMP(power_report_enable, !power_report_strap_pin);
    `CMP(ss_product_id_low, DEF_LO);
    `CMP(product_id_high, otp_product_id_high);
    $display("test reset done");
    rnd();
    wr(OFF_PRODUCT_ID_LOW, v);
    rd(OFF_PRODUCT_ID_LOW, v);
    `CMP(ss_product_id_low, v);
    `CMP(usb2_product_id_low, v ^ USB2_PID_XOR);
    wr(OFF_PRODUCT_ID_LOW, 8'h00);
    rd(OFF_PRODUCT_ID_LOW, DEF_LO);
    wr(OFF_DEVICE_CONFIGURATION, 8'hFF);
    rd(OFF_DEVICE_CONFIGURATION, 8'hFE);
    `CMP(cfg_bits, 6'h3F);
    wr(OFF_CHARGING_SUPPORT, 8'hFF);
    rd(OFF_CHARGING_SUPPORT, 8'h0F);
    `CMP(charging_port_enable, 4'hF);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_DEVICE_CONFIGURATION, k ? 8'hC0 : 8'h00);
      gw(OFF_STRING_FIRST, {k[0], 1'b0});
      gw(OFF_LANG_FIRST, {k[0], 1'b0});
      gw(OFF_SERIAL_FIRST, {1'b0, k[0]});
      gw(OFF_SERIAL_LENGTH, {1'b0, k[0]});
    end
    $display("test registers done");
    wr(OFF_DEVICE_CONFIGURATION, 8'h02);
    host_timeout = v;
    settle();
    `CMP(link_timeout, TIMEOUT_MAX);
    host_timeout = 8'h00;
    settle();
    `CMP(link_timeout, 8'h00);
    wr(OFF_DEVICE_CONFIGURATION, 8'h20);
    `CMP(low_power_link_allowed, 1'b0);
    host_timeout = v;
    settle();
    `CMP(link_timeout, v);
    force_accept_event = 1'b1;
    @(negedge clk);
    force_accept_event = 1'b0;
    `CMP(low_power_link_allowed, 1'b1);
    upstream_disconnect = 1'b1;
    settle();
    upstream_disconnect = 1'b0;
    `CMP(low_power_link_allowed, 1'b0);
    wr(OFF_DEVICE_CONFIGURATION, 8'h08);
    `CMP(power_report_enable, 1'b1);
    port_power_request = 4'h1;
    settle();
    `CMP(port_power_enable, 4'hF);
    wr(OFF_DEVICE_CONFIGURATION, 8'h00);
    port_power_request = 4'h5;
    settle();
    `CMP(port_power_enable, 4'h5);
    wr(OFF_DEVICE_CONFIGURATION, 8'h04);
    `CMP(power_report_enable, 1'b0);
    settle();
    `CMP(port_power_enable, 4'hF);
    $display("test link and power done");
    tally_and_finish();
  end
endmodule
